// ==== hdl/ebid_map.svh ====
// ebid_map.svh: offsets, field positions and constants of the board id record block
// assumes inclusion by bare name from the decoder, the memory and the bench
`ifndef EBID_MAP_SVH
`define EBID_MAP_SVH

// record layout, byte offsets into the memory
`define EBID_OFS_HEADER   15'd0
`define EBID_OFS_REV      15'd4
`define EBID_OFS_NAME     15'd6
`define EBID_OFS_VERSION  15'd38
`define EBID_OFS_MAKER    15'd42
`define EBID_OFS_PART     15'd58
`define EBID_OFS_PINCNT   15'd74
`define EBID_OFS_SERIAL   15'd76
`define EBID_OFS_PINTAB   15'd88
`define EBID_OFS_I_3V3    15'd236
`define EBID_OFS_I_5V     15'd238
`define EBID_OFS_I_SYS    15'd240
`define EBID_OFS_DC       15'd242
`define EBID_OFS_FREE     15'd244
`define EBID_FREE_LEN     32543
`define EBID_MEM_DEPTH    32768
`define EBID_ERASED_BYTE  8'hff

// signature and format revision bytes
`define EBID_SIG0         8'haa
`define EBID_SIG1         8'h55
`define EBID_SIG2         8'h33
`define EBID_SIG3         8'hee
`define EBID_REV0         8'h41
`define EBID_REV1         8'h31
`define EBID_SCAN_LAST    3'd6

// per-pin word fields
`define EBID_PW_USED      15
`define EBID_PW_RSV_HI    14
`define EBID_PW_RSV_LO    7
`define EBID_PW_EDGE      6
`define EBID_PW_RX        5
`define EBID_PW_PULLDIR   4
`define EBID_PW_PULLDIS   3
`define EBID_PW_MUX_HI    2

// serial bus address of the memory, top strap tied high
`define EBID_I2C_BASE     7'h54

// register byte offsets
`define EBID_REG_ADDR     8'h00
`define EBID_REG_DATA     8'h04
`define EBID_REG_STATUS   8'h08
`define EBID_REG_WORD_OFS 8'h0c
`define EBID_REG_WORD     8'h10
`define EBID_REG_PIN_INFO 8'h14
`define EBID_REG_BUS_ADDR 8'h18

// status and control bit positions
`define EBID_ST_VALID     0
`define EBID_ST_BUSY      1
`define EBID_ST_WP_N      2
`define EBID_ST_REFUSED   3
`define EBID_ST_REV_OK    4
`define EBID_WO_ANALOG    16

`define EBID_RESP_OKAY    2'b00
`define EBID_RESP_DECERR  2'b11

`endif

// ==== hdl/ebid_pkg.sv ====
// ebid_pkg: types of the board id record block
// defines its own state and field codes; needs nothing from ebid_map.svh
package ebid_pkg;
  typedef logic [14:0] ebid_addr_t;
  typedef logic [15:0] ebid_word_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_SCAN = 7'b0000010,
    ST_WHI  = 7'b0000100,
    ST_WLO  = 7'b0001000,
    ST_WEND = 7'b0010000,
    ST_RDB  = 7'b0100000,
    ST_RDE  = 7'b1000000
  } ebid_state_t;

  typedef enum logic [3:0] {
    FLD_HEADER  = 4'h0,
    FLD_REV     = 4'h1,
    FLD_NAME    = 4'h2,
    FLD_VERSION = 4'h3,
    FLD_MAKER   = 4'h4,
    FLD_PART    = 4'h5,
    FLD_PINCNT  = 4'h6,
    FLD_SERIAL  = 4'h7,
    FLD_PINTAB  = 4'h8,
    FLD_I_3V3   = 4'h9,
    FLD_I_5V    = 4'ha,
    FLD_I_SYS   = 4'hb,
    FLD_DC      = 4'hc,
    FLD_FREE    = 4'hd
  } ebid_field_t;
endpackage

// ==== hdl/ebid_pin_decode.sv ====
// ebid_pin_decode: splits a fetched record word into pad settings
// assumes the word is already assembled most significant byte first
`timescale 1ns/1ns
`default_nettype none
`include "ebid_map.svh"
module ebid_pin_decode import ebid_pkg::*; (
  input  wire ebid_word_t  word,
  input  wire logic        analog,
  input  wire ebid_field_t field,
  output logic             pin_used,
  output logic             edge_rate_select,
  output logic             rx_enable,
  output logic             pull_direction_select,
  output logic             pull_disable,
  output logic [2:0]       mux_mode,
  output logic             reserved_set,
  output logic             supplies_5v
);
  logic is_pin;
  logic full;

  // analog entries carry only the used flag; the rest is forced to zero
  assign is_pin = (field == FLD_PINTAB);
  assign full   = is_pin & ~analog;

  assign pin_used              = is_pin & word[`EBID_PW_USED];
  assign edge_rate_select      = full & word[`EBID_PW_EDGE];
  assign rx_enable             = full & word[`EBID_PW_RX];
  assign pull_direction_select = full & word[`EBID_PW_PULLDIR];
  assign pull_disable          = full & word[`EBID_PW_PULLDIS];
  assign mux_mode              = full ? word[`EBID_PW_MUX_HI:0] : 3'h0;
  assign reserved_set          = full & (|word[`EBID_PW_RSV_HI:`EBID_PW_RSV_LO]);
  assign supplies_5v           = (field == FLD_DC) & (|word);
endmodule
`default_nettype wire

// ==== hdl/ebid_id_eeprom.sv ====
// ebid_id_eeprom: board identification record memory with an AXI4-Lite register slave
// assumes one clock aclk, synchronous low reset, write-protect and straps synchronous to aclk
// Operation
// - writes accepted only with protect input low
// - multi-byte fields stored most significant first
// - four signature bytes at offset zero
// - offset 4 holds revision text A1
// - offset 6: 32-byte board name
// - offset 38: four-byte hardware version
// - offset 42: 16-byte producer name
// - offset 58: 16-byte part number
// - offset 74: two-byte used pin count
// - offset 76: 12-character serial string
// - offset 88: 148-byte per-pin word table
// - offsets 236-240: three rail current limits
// - offset 242: nonzero means 5V rail supplied
// - from 244: free data, never interpreted
// - bit 15 marks pin used
// - bit 6 selects slow edge rate
// - bit 5 enables input receiver
// - bit 4 selects pull up
// - bit 3 disables the pull
// - bits 2..0 pick mux mode
// - analog pin words: only bit 15 counts
// - bus address 0x54 to 0x57 by straps
`timescale 1ns/1ns
`default_nettype none
`include "ebid_map.svh"
module ebid_id_eeprom import ebid_pkg::*; (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        write_protect_n,
  input  wire logic [1:0]  addr_strap,
  output logic             record_valid
);
  // power-up image is an erased part; the bytes are non-volatile, so reset leaves them alone
  logic [7:0]  mem [0:`EBID_MEM_DEPTH-1] = '{default: `EBID_ERASED_BYTE};
  ebid_state_t state_q;
  logic        aw_held_q;
  logic [7:0]  awaddr_q;
  logic        w_held_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;
  ebid_addr_t  addr_q;
  ebid_addr_t  word_ofs_q;
  logic        analog_q;
  ebid_word_t  word_q;
  logic [7:0]  hi_q;
  logic [7:0]  mem_q;
  ebid_addr_t  rd_addr;
  logic [2:0]  scan_cnt_q;
  logic        sig_ok_q;
  logic        rev_ok_q;
  logic        record_valid_q;
  logic        refused_q;
  logic [1:0]  strap_q;
  logic        do_wr;
  logic        wr_data;
  logic        wr_allow;
  logic        ar_take;
  logic [31:0] rd_word;
  logic [1:0]  rd_resp;
  ebid_field_t field;
  logic        pin_used;
  logic        edge_rate_select;
  logic        rx_enable;
  logic        pull_direction_select;
  logic        pull_disable;
  logic [2:0]  mux_mode;
  logic        reserved_set;
  logic        supplies_5v;

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == `EBID_REG_ADDR) || (a == `EBID_REG_DATA) || (a == `EBID_REG_STATUS) ||
              (a == `EBID_REG_WORD_OFS) || (a == `EBID_REG_WORD) || (a == `EBID_REG_PIN_INFO) ||
              (a == `EBID_REG_BUS_ADDR);
  endfunction

  function automatic logic [7:0] expect_byte(input logic [2:0] i);
    case (i)
      3'd0:    expect_byte = `EBID_SIG0;
      3'd1:    expect_byte = `EBID_SIG1;
      3'd2:    expect_byte = `EBID_SIG2;
      3'd3:    expect_byte = `EBID_SIG3;
      3'd4:    expect_byte = `EBID_REV0;
      default: expect_byte = `EBID_REV1;
    endcase
  endfunction

  function automatic ebid_field_t field_of(input ebid_addr_t a);
    if (a < `EBID_OFS_REV) begin
      field_of = FLD_HEADER;
    end else if (a < `EBID_OFS_NAME) begin
      field_of = FLD_REV;
    end else if (a < `EBID_OFS_VERSION) begin
      field_of = FLD_NAME;
    end else if (a < `EBID_OFS_MAKER) begin
      field_of = FLD_VERSION;
    end else if (a < `EBID_OFS_PART) begin
      field_of = FLD_MAKER;
    end else if (a < `EBID_OFS_PINCNT) begin
      field_of = FLD_PART;
    end else if (a < `EBID_OFS_SERIAL) begin
      field_of = FLD_PINCNT;
    end else if (a < `EBID_OFS_PINTAB) begin
      field_of = FLD_SERIAL;
    end else if (a < `EBID_OFS_I_3V3) begin
      field_of = FLD_PINTAB;
    end else if (a < `EBID_OFS_I_5V) begin
      field_of = FLD_I_3V3;
    end else if (a < `EBID_OFS_I_SYS) begin
      field_of = FLD_I_5V;
    end else if (a < `EBID_OFS_DC) begin
      field_of = FLD_I_SYS;
    end else if (a < `EBID_OFS_FREE) begin
      field_of = FLD_DC;
    end else begin
      field_of = FLD_FREE;
    end
  endfunction

  // writes wait for the idle state so the memory never changes under a fetch or scan
  assign awready = ~aw_held_q;
  assign wready  = ~w_held_q;
  assign do_wr   = aw_held_q & w_held_q & ~bvalid_q & (state_q == ST_IDLE);
  assign wr_data = do_wr & (awaddr_q == `EBID_REG_DATA) & wstrb_q[0];
  assign wr_allow = wr_data & ~write_protect_n;
  assign arready = (state_q == ST_IDLE) & ~rvalid_q & ~do_wr;
  assign ar_take = arvalid & arready;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign rvalid  = rvalid_q;
  assign rresp   = rresp_q;
  assign rdata   = rdata_q;
  assign record_valid = record_valid_q;
  assign field   = field_of(word_ofs_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q  <= 8'h00;
    end else if (awvalid && awready) begin
      aw_held_q <= 1'b1;
      awaddr_q  <= awaddr;
    end else if (do_wr) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (wvalid && wready) begin
      w_held_q <= 1'b1;
      wdata_q  <= wdata;
      wstrb_q  <= wstrb;
    end else if (do_wr) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `EBID_RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q  <= reg_hit(awaddr_q) ? `EBID_RESP_OKAY : `EBID_RESP_DECERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // memory: one read port for scan, word fetch and byte reads
  always_comb begin
    case (state_q)
      ST_SCAN: rd_addr = {12'h000, scan_cnt_q};
      ST_WHI:  rd_addr = word_ofs_q;
      ST_WLO:  rd_addr = word_ofs_q + 15'd1;
      default: rd_addr = addr_q;
    endcase
  end

  always_ff @(posedge aclk) begin
    mem_q <= mem[rd_addr];
    if (wr_allow) begin
      mem[addr_q] <= wdata_q[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      refused_q <= 1'b0;
    end else if (wr_data && write_protect_n) begin
      refused_q <= 1'b1;
    end else if (do_wr && awaddr_q == `EBID_REG_STATUS && wdata_q[`EBID_ST_REFUSED]) begin
      refused_q <= 1'b0;
    end
  end

  // byte pointer steps after each data access, like a sequential serial read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_q <= 15'h0000;
    end else if (do_wr && awaddr_q == `EBID_REG_ADDR) begin
      addr_q <= wdata_q[14:0];
    end else if (wr_data || state_q == ST_RDE) begin
      addr_q <= addr_q + 15'd1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      word_ofs_q <= 15'h0000;
      analog_q   <= 1'b0;
    end else if (do_wr && awaddr_q == `EBID_REG_WORD_OFS) begin
      word_ofs_q <= wdata_q[14:0];
      analog_q   <= wdata_q[`EBID_WO_ANALOG];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_q <= addr_strap;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_SCAN;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (do_wr && awaddr_q == `EBID_REG_WORD_OFS) begin
            state_q <= ST_WHI;
          end else if (wr_allow && addr_q <= {12'h000, `EBID_SCAN_LAST}) begin
            state_q <= ST_SCAN;
          end else if (ar_take && araddr == `EBID_REG_DATA) begin
            state_q <= ST_RDB;
          end
        end
        ST_SCAN: state_q <= (scan_cnt_q == `EBID_SCAN_LAST) ? ST_IDLE : ST_SCAN;
        ST_WHI:  state_q <= ST_WLO;
        ST_WLO:  state_q <= ST_WEND;
        ST_WEND: state_q <= ST_IDLE;
        ST_RDB:  state_q <= ST_RDE;
        ST_RDE:  state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // signature check: record is flagged absent until all four bytes match
  always_ff @(posedge aclk) begin
    if (!aresetn || state_q != ST_SCAN) begin
      scan_cnt_q <= 3'd0;
      sig_ok_q   <= 1'b1;
    end else begin
      scan_cnt_q <= scan_cnt_q + 3'd1;
      if (scan_cnt_q != 3'd0 && scan_cnt_q <= 3'd4 && mem_q != expect_byte(scan_cnt_q - 3'd1)) begin
        sig_ok_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      record_valid_q <= 1'b0;
      rev_ok_q       <= 1'b0;
      hi_q           <= 8'h00;
    end else if (state_q == ST_SCAN) begin
      if (scan_cnt_q == 3'd0) begin
        record_valid_q <= 1'b0;
      end
      if (scan_cnt_q == 3'd5) begin
        record_valid_q <= sig_ok_q;
        rev_ok_q       <= (mem_q == `EBID_REV0);
      end
      if (scan_cnt_q == `EBID_SCAN_LAST) begin
        rev_ok_q <= rev_ok_q & (mem_q == `EBID_REV1);
      end
    end else if (state_q == ST_WLO) begin
      hi_q <= mem_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      word_q <= 16'h0000;
    end else if (state_q == ST_WEND) begin
      word_q <= {hi_q, mem_q};
    end
  end

  ebid_pin_decode u_decode (
    .word                  (word_q),
    .analog                (analog_q),
    .field                 (field),
    .pin_used              (pin_used),
    .edge_rate_select      (edge_rate_select),
    .rx_enable             (rx_enable),
    .pull_direction_select (pull_direction_select),
    .pull_disable          (pull_disable),
    .mux_mode              (mux_mode),
    .reserved_set          (reserved_set),
    .supplies_5v           (supplies_5v)
  );

  always_comb begin
    rd_resp = `EBID_RESP_OKAY;
    case (araddr)
      `EBID_REG_ADDR:     rd_word = {17'h0, addr_q};
      `EBID_REG_STATUS:   rd_word = {27'h0, rev_ok_q, refused_q, write_protect_n, 1'b0, record_valid_q};
      `EBID_REG_WORD_OFS: rd_word = {15'h0, analog_q, 1'b0, word_ofs_q};
      `EBID_REG_WORD:     rd_word = {16'h0, word_q};
      `EBID_REG_PIN_INFO: rd_word = {12'h0, field, pin_used, 6'h0, supplies_5v, reserved_set,
                                     edge_rate_select, rx_enable, pull_direction_select, pull_disable,
                                     mux_mode};
      `EBID_REG_BUS_ADDR: rd_word = {25'h0, `EBID_I2C_BASE | {5'h00, strap_q}};
      default: begin
        rd_word = 32'h0000_0000;
        rd_resp = `EBID_RESP_DECERR;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q  <= `EBID_RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else if (ar_take && araddr != `EBID_REG_DATA) begin
      rvalid_q <= 1'b1;
      rresp_q  <= rd_resp;
      rdata_q  <= rd_word;
    end else if (state_q == ST_RDE) begin
      rvalid_q <= 1'b1;
      rresp_q  <= `EBID_RESP_OKAY;
      rdata_q  <= {24'h0, mem_q};
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  sequence scan_entry;
    state_q != ST_SCAN ##1 state_q == ST_SCAN;
  endsequence

  sequence fetch_steps;
    state_q == ST_WHI ##1 state_q == ST_WLO ##1 state_q == ST_WEND;
  endsequence

  chk_wp_refuse: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_data && write_protect_n) |=> refused_q && bvalid_q && mem[$past(addr_q)] == $past(mem[addr_q]))
    else $error("write taken while protect input high");

  chk_wp_allow: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_data && !write_protect_n) |=> mem[$past(addr_q)] == $past(wdata_q[7:0]))
    else $error("permitted write not stored");

  chk_word_order: assert property (@(posedge aclk) disable iff (!aresetn)
    fetch_steps |=> word_q == {mem[word_ofs_q], mem[word_ofs_q + 15'd1]})
    else $error("fetched word not most significant byte first");

  chk_scan_len: assert property (@(posedge aclk) disable iff (!aresetn)
    scan_entry |-> state_q == ST_SCAN [*7] ##1 state_q == ST_IDLE)
    else $error("signature scan length wrong");

  chk_sig_valid: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ST_SCAN && scan_cnt_q == `EBID_SCAN_LAST) |=> record_valid_q ==
      (mem[0] == `EBID_SIG0 && mem[1] == `EBID_SIG1 && mem[2] == `EBID_SIG2 && mem[3] == `EBID_SIG3))
    else $error("record valid flag disagrees with signature");

  chk_rev_text: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ST_SCAN && scan_cnt_q == `EBID_SCAN_LAST) |=> rev_ok_q ==
      (mem[4] == `EBID_REV0 && mem[5] == `EBID_REV1))
    else $error("revision flag disagrees with memory");

  chk_pin_fields: assert property (@(posedge aclk) disable iff (!aresetn)
    (field == FLD_PINTAB && !analog_q) |-> pin_used == word_q[15] && edge_rate_select == word_q[6] &&
      rx_enable == word_q[5] && pull_direction_select == word_q[4] && pull_disable == word_q[3] &&
      mux_mode == word_q[2:0])
    else $error("pin word fields misdecoded");

  chk_analog_mask: assert property (@(posedge aclk) disable iff (!aresetn)
    analog_q |-> {edge_rate_select, rx_enable, pull_direction_select, pull_disable, mux_mode} == 7'h00)
    else $error("analog pin word decoded beyond used flag");

  chk_byte_read: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_take && araddr == `EBID_REG_DATA) |-> ##3 rvalid_q && rdata_q == {24'h0, mem[$past(addr_q, 3)]})
    else $error("byte read returned wrong data");

  chk_bus_addr: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_take && araddr == `EBID_REG_BUS_ADDR) |=> rvalid_q && rdata_q[6:2] == 5'b10101)
    else $error("bus address outside its range");
endmodule
`default_nettype wire

// ==== verification/ebid_board_model.sv ====
// ebid_board_model: board side of the id memory, protect pull-up and address jumpers
// assumes the bench grounds the test point while it programs the record
`timescale 1ns/1ns
`default_nettype none
module ebid_board_model (
  input  wire logic       tp_grounded,
  input  wire logic [1:0] jumper,
  output logic            write_protect_n,
  output logic [1:0]      addr_strap
);
  // pull-up keeps the memory protected unless the test point is grounded
  assign write_protect_n = ~tp_grounded;
  assign addr_strap      = jumper;
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// tb: self-checking bench for the board id record block
// assumes an AXI4-Lite master here and the board model on the protect and strap pins
`timescale 1ns/1ns
`default_nettype none
`include "ebid_map.svh"
module tb;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, tp;
  logic        awready, wready, bvalid, arready, rvalid, record_valid, wp_n;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, strap, jumper, rr, br;
  int          n_mismatch, check_count;

  ebid_id_eeprom i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .write_protect_n(wp_n), .addr_strap(strap), .record_valid(record_valid));
  ebid_board_model i_board (.tp_grounded(tp), .jumper(jumper), .write_protect_n(wp_n), .addr_strap(strap));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic conclude;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // one edge first, so a strobe lowered by the last call is never raised in the same step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (aw && awready === 1'b1) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1) begin
        br = bresp;
        bready <= 1'b0;
        return;
      end
    end
    n_mismatch++;
    conclude();
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar;
    ar = 1'b1;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (ar && arready === 1'b1) begin
        ar = 1'b0;
        arvalid <= 1'b0;
      end
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        return;
      end
    end
    n_mismatch++;
    conclude();
  endtask

  task automatic t_load;
    logic [7:0] b[6] = '{8'haa, 8'h55, 8'h33, 8'hee, 8'h41, 8'h31};
    // erased part: no signature yet, so the record must read as absent
    rd(`EBID_REG_STATUS, rv, rr);
    chk(rv, 32'h4);
    chk({31'h0, record_valid}, 32'h0);
    tp <= 1'b1;
    wr(`EBID_REG_ADDR, 32'h0);
    foreach (b[i]) wr(`EBID_REG_DATA, {24'h0, b[i]});
    rd(`EBID_REG_STATUS, rv, rr);
    chk(rv, 32'h11);
    chk({31'h0, record_valid}, 32'h1);
  endtask

  task automatic t_protect;
    tp <= 1'b0;
    wr(`EBID_REG_ADDR, 32'h0);
    wr(`EBID_REG_DATA, 32'h0);
    chk({30'h0, br}, 32'h0);
    rd(`EBID_REG_STATUS, rv, rr);
    chk(rv, 32'h1d);
    wr(`EBID_REG_ADDR, 32'h0);
    rd(`EBID_REG_DATA, rv, rr);
    chk(rv, 32'haa);
    wr(`EBID_REG_STATUS, 32'h8);
    rd(`EBID_REG_STATUS, rv, rr);
    chk(rv, 32'h15);
  endtask

  // second word breaks the reserved field on purpose to see it flagged
  task automatic t_pins;
    logic [7:0] b[6] = '{8'h80, 8'h6d, 8'h7f, 8'h92, 8'h01, 8'hf4};
    tp <= 1'b1;
    wr(`EBID_REG_ADDR, 32'd88);
    foreach (b[i]) begin
      if (i == 4)
        wr(`EBID_REG_ADDR, 32'd242);
      wr(`EBID_REG_DATA, {24'h0, b[i]});
    end
    wr(`EBID_REG_WORD_OFS, 32'd88);
    rd(`EBID_REG_WORD, rv, rr);
    chk(rv, 32'h806d);
    rd(`EBID_REG_PIN_INFO, rv, rr);
    chk(rv, 32'h0008806d);
    wr(`EBID_REG_WORD_OFS, 32'd90);
    rd(`EBID_REG_PIN_INFO, rv, rr);
    chk(rv, 32'h00080092);
    wr(`EBID_REG_WORD_OFS, 32'h0001_0058);
    rd(`EBID_REG_PIN_INFO, rv, rr);
    chk(rv, 32'h00088000);
    wr(`EBID_REG_WORD_OFS, 32'd242);
    rd(`EBID_REG_WORD, rv, rr);
    chk(rv, 32'h01f4);
    rd(`EBID_REG_PIN_INFO, rv, rr);
    chk(rv, 32'h000c0100);
  endtask

  task automatic t_fields;
    int ofs[16] = '{0, 4, 6, 38, 42, 58, 74, 76, 87, 88, 236, 238, 240, 242, 244, 32767};
    int fc[16]  = '{0, 1, 2, 3, 4, 5, 6, 7, 7, 8, 9, 10, 11, 12, 13, 13};
    foreach (ofs[i]) begin
      wr(`EBID_REG_WORD_OFS, 32'(ofs[i]));
      rd(`EBID_REG_PIN_INFO, rv, rr);
      chk({28'h0, rv[19:16]}, 32'(fc[i]));
    end
  endtask

  task automatic t_bus;
    rd(`EBID_REG_BUS_ADDR, rv, rr);
    chk(rv, 32'h56);
    rd(8'h1c, rv, rr);
    chk({30'h0, rr}, 32'h3);
    chk(rv, 32'h0);
    // unmapped write must be answered with a decode error and change nothing
    wr(8'h1c, 32'h0);
    chk({30'h0, br}, 32'h3);
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, tp} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    aresetn = 1'b0;
    jumper = 2'b10;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_load();
    t_protect();
    t_pins();
    t_fields();
    t_bus();
    conclude();
  end
endmodule
`default_nettype wire
